/* File: core/fdm_core.sv */
// What this block does
// RULE_01 - battery loss flag follows low-battery condition
// RULE_02 - supply over/under flags, supply interrupt code
// RULE_03 - regulator warning flag outside low-power modes
// RULE_04 - regulator overheat: reset, then sleep with regulator off
// RULE_05 - reset with vdd low, no undervoltage: sleep
// RULE_06 - rx pin short: transmitter off, flag set
// RULE_07 - tx low too long: transmitter off, flag
// RULE_08 - line driver overheat: transmitter off, flag
// RULE_09 - switch overheat: both off until write
// RULE_10 - switch overheat sets all four switch flags
// RULE_11 - open-load flags in normal modes only
// RULE_12 - current limit flags, switch stays on
// RULE_13 - floating watchdog pin: fallback timebase, error flag
// RULE_14 - interrupts only in normal, request, stop
// RULE_15 - masked source: no pending flag, irq high
// RULE_16 - host reads status after returning to normal
// RULE_17 - line flags cleared by read when gone
// RULE_18 - transmitter re-enabled once tx input high
// RULE_19 - switch interrupt needs switch mask set
// RULE_20 - normal request timeout forces reset
// RULE_21 - irq low while unmasked source pending
// RULE_22 - overvoltage switch shutdown when enabled, normal
`timescale 1ns/10ps
module fdm_core import fdm_pkg::*; #(
    parameter logic [23:0] TXSTUCK_LIMIT = TXSTUCK_CYCLES,
    parameter logic [23:0] NREQ_LIMIT    = NREQ_CYCLES
) (
    input  wire logic       sys_clk_in,
    input  wire logic       rst_n_in,
    input  wire logic       clk_en_in,
    // fault conditions from analog monitors and pins
    input  wire logic       batt_low_in,
    input  wire logic       supply_over_in,
    input  wire logic       supply_under_in,
    input  wire logic       reg_warn_in,
    input  wire logic       reg_overtemp_in,
    input  wire logic       vdd_under_in,
    input  wire logic       rx_short_in,
    input  wire logic       tx_pin_in,
    input  wire logic       line_overtemp_in,
    input  wire logic       switch_overtemp_in,
    input  wire logic [1:0] switch_open_in,
    input  wire logic [1:0] switch_limit_in,
    input  wire logic       wd_pin_float_in,
    input  wire logic       wake_in,
    // host side commands
    input  wire logic       go_normal_in,
    input  wire logic       go_stop_in,
    input  wire logic       go_sleep_in,
    input  wire logic [1:0] status_sel_in,
    input  wire logic       status_rd_in,
    input  wire logic       irq_src_rd_in,
    input  wire logic       switch_ctrl_wr_in,
    input  wire logic [1:0] switch_ctrl_in,
    input  wire logic       high_voltage_shutdown_enable_in,
    input  wire logic       supply_irq_mask_in,
    input  wire logic       line_irq_mask_in,
    input  wire logic       switch_irq_mask_in,
    // results
    output logic [3:0]      status_data_out,
    output logic [3:0]      irq_source_out,
    output logic            irq_n_out,
    output logic [1:0]      switch_on_out,
    output logic            tx_enable_out,
    output logic            reg_enable_out,
    output logic            host_reset_n_out,
    output logic            wd_fallback_out,
    output logic [2:0]      mode_out
);
    logic [15:0] raw_vec;
    logic [15:0] syn_vec;
    logic        batt_s, over_s, under_s, warn_s, regot_s, vddun_s, short_s, txd_s;
    logic        line_driver_overtemp_flag_s, swot_s, wdflt_s, wake_s;
    logic [1:0]  open_s, lim_s;

    // every pin condition passes two flip-flops
    assign raw_vec = {batt_low_in, supply_over_in, supply_under_in, reg_warn_in,
                      reg_overtemp_in, vdd_under_in, rx_short_in, tx_pin_in,
                      line_overtemp_in, switch_overtemp_in, switch_open_in,
                      switch_limit_in, wd_pin_float_in, wake_in};
    assign {batt_s, over_s, under_s, warn_s, regot_s, vddun_s, short_s, txd_s,
            line_driver_overtemp_flag_s, swot_s, open_s, lim_s, wdflt_s, wake_s} = syn_vec;

    fdm_sync #(.W(16)) u_sync (
        .sys_clk_in (sys_clk_in),
        .rst_n_in   (rst_n_in),
        .clk_en_in  (clk_en_in),
        .async_in   (raw_vec),
        .sync_out   (syn_vec)
    );

    fdm_mode_t   mode_ff, nxt_mode;
    logic        sleep_pend_ff, nxt_sleep_pend;
    logic        dom_expired, nreq_expired;

    fdm_timer #(.LIMIT(TXSTUCK_LIMIT)) u_dom_timer (
        .sys_clk_in  (sys_clk_in),
        .rst_n_in    (rst_n_in),
        .clk_en_in   (clk_en_in),
        .run_in      (!txd_s),
        .expired_out (dom_expired)
    );

    fdm_timer #(.LIMIT(NREQ_LIMIT)) u_nreq_timer (
        .sys_clk_in  (sys_clk_in),
        .rst_n_in    (rst_n_in),
        .clk_en_in   (clk_en_in),
        .run_in      (mode_ff == FDM_NORM_REQ),
        .expired_out (nreq_expired)
    );

    // true in modes where interrupts may be raised
    function automatic logic irq_mode(input fdm_mode_t m);
        return (m == FDM_NORMAL) || (m == FDM_NORM_REQ) || (m == FDM_STOP);
    endfunction

    // operating mode sequencing
    always_comb begin
        nxt_mode       = mode_ff;
        nxt_sleep_pend = sleep_pend_ff;
        if (clk_en_in) begin
            if (regot_s && mode_ff != FDM_SLEEP) begin
                nxt_mode       = FDM_RESET;  // RULE_04
                nxt_sleep_pend = 1'b1;
            end else begin
                unique case (mode_ff)
                    FDM_RESET: begin
                        if (sleep_pend_ff || (vddun_s && !under_s)) begin
                            nxt_mode       = FDM_SLEEP;  // RULE_04 RULE_05
                            nxt_sleep_pend = 1'b0;
                        end else if (!vddun_s) begin
                            nxt_mode = FDM_NORM_REQ;
                        end
                    end
                    FDM_NORM_REQ: begin
                        if (nreq_expired)
                            nxt_mode = FDM_RESET;  // RULE_20
                        else if (go_normal_in)
                            nxt_mode = FDM_NORMAL;
                    end
                    FDM_NORMAL: begin
                        if (go_sleep_in)
                            nxt_mode = FDM_SLEEP;
                        else if (go_stop_in)
                            nxt_mode = FDM_STOP;
                    end
                    FDM_STOP: begin
                        if (wake_s)
                            nxt_mode = FDM_NORMAL;
                    end
                    FDM_SLEEP: begin
                        if (wake_s)
                            nxt_mode = FDM_RESET;
                    end
                    default: nxt_mode = FDM_RESET;
                endcase
            end
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            mode_ff          <= FDM_RESET;
            sleep_pend_ff    <= 1'b0;
            reg_enable_out   <= 1'b1;
            host_reset_n_out <= 1'b0;
            mode_out         <= FDM_RESET;
        end else begin
            mode_ff          <= nxt_mode;
            sleep_pend_ff    <= nxt_sleep_pend;
            reg_enable_out   <= nxt_mode != FDM_SLEEP;  // RULE_04
            host_reset_n_out <= nxt_mode != FDM_RESET;
            mode_out         <= nxt_mode;
        end
    end

    // status flags and clear-on-read of the line flags
    logic [3:0] sup_ff, nxt_sup, lin_ff, nxt_lin, sw_ff, nxt_sw, wd_ff, nxt_wd;
    logic       lin_rd;

    assign lin_rd = status_rd_in && status_sel_in == SEL_LINE;

    always_comb begin
        nxt_sup = sup_ff;
        nxt_lin = lin_ff;
        nxt_sw  = sw_ff;
        nxt_wd  = wd_ff;
        if (clk_en_in) begin
            nxt_sup[SUP_BATT_BIT]  = batt_s;  // RULE_01
            nxt_sup[SUP_OVER_BIT]  = over_s;  // RULE_02
            nxt_sup[SUP_UNDER_BIT] = under_s;  // RULE_02
            nxt_sup[SUP_WARN_BIT]  = warn_s && mode_ff != FDM_SLEEP
                                     && mode_ff != FDM_STOP;  // RULE_03
            // clear only when gone, a new set wins over the read
            if (lin_rd && !short_s)
                nxt_lin[LIN_SHORT_BIT] = 1'b0;  // RULE_17
            if (lin_rd && txd_s)
                nxt_lin[LIN_DOM_BIT] = 1'b0;  // RULE_17
            if (short_s)
                nxt_lin[LIN_SHORT_BIT] = 1'b1;  // RULE_06
            if (dom_expired)
                nxt_lin[LIN_DOM_BIT] = 1'b1;  // RULE_07
            nxt_lin[LIN_OT_BIT] = line_driver_overtemp_flag_s;  // RULE_08
            nxt_lin[0]          = 1'b0;
            if (swot_s) begin
                nxt_sw = SW_ALL_FLAGS;  // RULE_10
            end else begin
                nxt_sw[SW1_OPEN_BIT] = open_s[0] && (mode_ff == FDM_NORMAL
                                       || mode_ff == FDM_NORM_REQ);  // RULE_11
                nxt_sw[SW2_OPEN_BIT] = open_s[1] && (mode_ff == FDM_NORMAL
                                       || mode_ff == FDM_NORM_REQ);  // RULE_11
                nxt_sw[SW1_LIM_BIT]  = lim_s[0];  // RULE_12
                nxt_sw[SW2_LIM_BIT]  = lim_s[1];  // RULE_12
            end
            nxt_wd             = STATUS_RST;
            nxt_wd[WD_ERR_BIT] = wdflt_s;  // RULE_13
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            sup_ff <= STATUS_RST;
            lin_ff <= STATUS_RST;
            sw_ff  <= STATUS_RST;
            wd_ff  <= STATUS_RST;
        end else begin
            sup_ff <= nxt_sup;
            lin_ff <= nxt_lin;
            sw_ff  <= nxt_sw;
            wd_ff  <= nxt_wd;
        end
    end

    // read port, watchdog fallback and corrective actions
    logic [3:0] nxt_rd_data;
    logic       tx_off_ff, nxt_tx_off;
    logic       sw_off_ff, nxt_sw_off;
    logic [1:0] nxt_sw_on;
    logic       hv_trip;

    assign hv_trip = high_voltage_shutdown_enable_in && over_s && mode_ff == FDM_NORMAL;

    always_comb begin
        nxt_rd_data = status_data_out;
        nxt_tx_off  = tx_off_ff;
        nxt_sw_off  = sw_off_ff;
        if (clk_en_in) begin
            if (status_rd_in) begin
                unique case (status_sel_in)
                    SEL_SUPPLY:   nxt_rd_data = sup_ff;
                    SEL_LINE:     nxt_rd_data = lin_ff;
                    SEL_SWITCH:   nxt_rd_data = sw_ff;
                    SEL_WATCHDOG: nxt_rd_data = wd_ff;
                endcase
            end
            if (short_s || line_driver_overtemp_flag_s || dom_expired)
                nxt_tx_off = 1'b1;  // RULE_06 RULE_07 RULE_08
            else if (txd_s)
                nxt_tx_off = 1'b0;  // RULE_18
            if (swot_s || hv_trip)
                nxt_sw_off = 1'b1;  // RULE_09 RULE_22
            else if (switch_ctrl_wr_in)
                nxt_sw_off = 1'b0;  // RULE_09 RULE_22
        end
        nxt_sw_on = nxt_sw_off ? 2'h0 : switch_ctrl_in;  // RULE_12
    end

    always_ff @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            status_data_out <= STATUS_RST;
            tx_off_ff       <= 1'b0;
            sw_off_ff       <= 1'b0;
            switch_on_out   <= 2'h0;
            tx_enable_out   <= 1'b0;
            wd_fallback_out <= 1'b0;
        end else begin
            status_data_out <= nxt_rd_data;
            tx_off_ff       <= nxt_tx_off;
            sw_off_ff       <= nxt_sw_off;
            if (clk_en_in) begin
                switch_on_out   <= nxt_sw_on;
                tx_enable_out   <= !nxt_tx_off;
                wd_fallback_out <= wdflt_s;  // RULE_13
            end
        end
    end

    // pending interrupt sources and interrupt line
    logic [2:0] pend_ff, nxt_pend;
    logic [2:0] prev_ff, nxt_prev;
    logic [2:0] evt;
    logic [3:0] nxt_code;

    always_comb begin
        nxt_prev = prev_ff;
        nxt_pend = pend_ff;
        evt      = 3'h0;
        if (clk_en_in) begin
            nxt_prev = {over_s || under_s || nxt_sup[SUP_WARN_BIT],
                        short_s || dom_expired || line_driver_overtemp_flag_s, swot_s};
            evt      = nxt_prev & ~prev_ff;
            if (irq_src_rd_in)
                nxt_pend = 3'h0;
            if (irq_mode(mode_ff)) begin  // RULE_14
                nxt_pend[2] = nxt_pend[2] || (evt[2] && supply_irq_mask_in);  // RULE_02 RULE_15
                nxt_pend[1] = nxt_pend[1] || (evt[1] && line_irq_mask_in);  // RULE_07 RULE_15
                nxt_pend[0] = nxt_pend[0] || (evt[0] && switch_irq_mask_in);  // RULE_09 RULE_19
            end
        end
        if (nxt_pend[2])
            nxt_code = IRQ_CODE_SUPPLY;
        else if (nxt_pend[1])
            nxt_code = IRQ_CODE_LINE;
        else if (nxt_pend[0])
            nxt_code = IRQ_CODE_SWITCH;
        else
            nxt_code = IRQ_CODE_NONE;
    end

    always_ff @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            pend_ff        <= 3'h0;
            prev_ff        <= 3'h0;
            irq_n_out      <= 1'b1;
            irq_source_out <= IRQ_CODE_NONE;
        end else begin
            pend_ff        <= nxt_pend;
            prev_ff        <= nxt_prev;
            irq_n_out      <= nxt_pend == 3'h0;  // RULE_21
            irq_source_out <= nxt_code;
        end
    end

    // checks, all on the system clock and off during reset
    default clocking chk_cb @(posedge sys_clk_in);
    endclocking
    default disable iff (!rst_n_in);

    sequence reset_then_sleep_s;
        mode_ff == FDM_RESET ##1 mode_ff == FDM_SLEEP;
    endsequence

    irq_line_pend_a: assert property (irq_n_out == (pend_ff == 3'h0))  // RULE_21
        else $error("irq line does not match pending sources");
    reg_overheat_a: assert property (  // RULE_04
        clk_en_in && regot_s && mode_ff != FDM_SLEEP ##1 clk_en_in && !regot_s
        |-> reset_then_sleep_s)
        else $error("regulator overheat did not pass reset into sleep");
    reset_to_sleep_a: assert property (  // RULE_05
        clk_en_in && mode_ff == FDM_RESET && vddun_s && !under_s && !regot_s
        |=> mode_ff == FDM_SLEEP)
        else $error("reset with vdd low did not enter sleep");
    short_tx_off_a: assert property (  // RULE_06
        clk_en_in && short_s |=> !tx_enable_out && lin_ff[LIN_SHORT_BIT])
        else $error("rx short did not stop transmitter");
    dom_flag_a: assert property (  // RULE_07
        clk_en_in && dom_expired |=> lin_ff[LIN_DOM_BIT] && !tx_enable_out)
        else $error("stuck dominant not flagged");
    switch_ot_a: assert property (  // RULE_10
        clk_en_in && swot_s |=> switch_on_out == 2'h0 && sw_ff == SW_ALL_FLAGS)
        else $error("switch overheat did not stop switches");
    no_irq_sleep_a: assert property (  // RULE_14
        !irq_mode(mode_ff) |=> (pend_ff & ~$past(pend_ff)) == 3'h0)
        else $error("interrupt raised in sleep or reset");
    switch_mask_a: assert property (  // RULE_19
        !switch_irq_mask_in && !pend_ff[0] |=> !pend_ff[0])
        else $error("masked switch interrupt became pending");
    nreq_timeout_a: assert property (  // RULE_20
        clk_en_in && nreq_expired && !regot_s |=> !host_reset_n_out)
        else $error("normal request timeout did not reset host");
    // a write in the cycle after the trip may release the switches one edge later
    hv_shutdown_a: assert property (  // RULE_22
        clk_en_in && hv_trip
        |=> switch_on_out == 2'h0 ##1 (switch_on_out == 2'h0 || $past(switch_ctrl_wr_in)))
        else $error("overvoltage shutdown of switches missing");
endmodule

/* File: core/fdm_pkg.sv */
package fdm_pkg;
    // clock and timing
    localparam int          CLK_HZ          = 10_000_000;
    localparam int          CYC_PER_MS      = CLK_HZ / 1000;
    localparam int          TXSTUCK_TIME_MS = 1000;
    localparam int          NREQ_TIME_MS    = 150;
    localparam logic [23:0] TXSTUCK_CYCLES  = 24'(TXSTUCK_TIME_MS * CYC_PER_MS);
    localparam logic [23:0] NREQ_CYCLES     = 24'(NREQ_TIME_MS * CYC_PER_MS);

    // status register selection
    localparam logic [1:0]  SEL_SUPPLY      = 2'h0;
    localparam logic [1:0]  SEL_LINE        = 2'h1;
    localparam logic [1:0]  SEL_SWITCH      = 2'h2;
    localparam logic [1:0]  SEL_WATCHDOG    = 2'h3;

    // supply_fault_status fields
    localparam int          SUP_BATT_BIT    = 0;
    localparam int          SUP_WARN_BIT    = 1;
    localparam int          SUP_UNDER_BIT   = 2;
    localparam int          SUP_OVER_BIT    = 3;
    // line_fault_status fields
    localparam int          LIN_OT_BIT      = 1;
    localparam int          LIN_DOM_BIT     = 2;
    localparam int          LIN_SHORT_BIT   = 3;
    // switch_fault_status fields
    localparam int          SW1_LIM_BIT     = 0;
    localparam int          SW1_OPEN_BIT    = 1;
    localparam int          SW2_LIM_BIT     = 2;
    localparam int          SW2_OPEN_BIT    = 3;
    // watchdog_fault_status fields
    localparam int          WD_ERR_BIT      = 2;

    localparam logic [3:0]  STATUS_RST      = 4'h0;
    localparam logic [3:0]  SW_ALL_FLAGS    = 4'hf;

    // interrupt source codes
    localparam logic [3:0]  IRQ_CODE_NONE   = 4'h0;
    localparam logic [3:0]  IRQ_CODE_SUPPLY = 4'h5;
    localparam logic [3:0]  IRQ_CODE_LINE   = 4'h4;
    localparam logic [3:0]  IRQ_CODE_SWITCH = 4'h2;

    typedef enum logic [2:0] {
        FDM_RESET    = 3'b000,
        FDM_NORM_REQ = 3'b001,
        FDM_NORMAL   = 3'b010,
        FDM_STOP     = 3'b011,
        FDM_SLEEP    = 3'b100
    } fdm_mode_t;
endpackage

/* File: core/fdm_sync.sv */
`timescale 1ns/10ps
// two-stage synchroniser bank for pin-level fault inputs
module fdm_sync import fdm_pkg::*; #(
    parameter int W = 1
) (
    input  wire logic         sys_clk_in,
    input  wire logic         rst_n_in,
    input  wire logic         clk_en_in,
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] sync_out
);
    logic [W-1:0] meta_ff;
    logic [W-1:0] nxt_meta;
    logic [W-1:0] nxt_sync;

    // first stage feeds only the second stage
    always_comb begin
        nxt_meta = clk_en_in ? async_in : meta_ff;
        nxt_sync = clk_en_in ? meta_ff : sync_out;
    end

    always_ff @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            meta_ff  <= '0;
            sync_out <= '0;
        end else begin
            meta_ff  <= nxt_meta;
            sync_out <= nxt_sync;
        end
    end
endmodule

/* File: core/fdm_timer.sv */
`timescale 1ns/10ps
// counts while run is high, expired stays high while run holds at the limit
module fdm_timer import fdm_pkg::*; #(
    parameter logic [23:0] LIMIT = 24'h000010
) (
    input  wire logic sys_clk_in,
    input  wire logic rst_n_in,
    input  wire logic clk_en_in,
    input  wire logic run_in,
    output logic      expired_out
);
    logic [23:0] cnt_ff;
    logic [23:0] nxt_cnt;

    // restart whenever run drops
    always_comb begin
        nxt_cnt = cnt_ff;
        if (clk_en_in) begin
            if (!run_in)
                nxt_cnt = '0;
            else if (cnt_ff != LIMIT)
                nxt_cnt = cnt_ff + 24'h000001;
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (!rst_n_in)
            cnt_ff <= '0;
        else
            cnt_ff <= nxt_cnt;
    end

    assign expired_out = run_in && (cnt_ff == LIMIT);
endmodule

/* File: bench/fdm_host.sv */
`timescale 1ns/10ps
// host model: mode command, source clear, switch write and status reads
module fdm_host (
    input  wire logic       clk_in,
    input  wire logic [3:0] data_in,
    output logic      [3:0] stb_out,
    output logic      [1:0] sel_out
);
    initial begin
        stb_out = 4'h0;
        sel_out = 2'h0;
    end
    // one-cycle strobe: 0 normal, 1 source clear, 2 switch write, 3 read
    task automatic pulse(input int k, input logic [1:0] s);
        @(posedge clk_in);
        #1;
        sel_out = s;
        stb_out[k] = 1'b1;
        @(posedge clk_in);
        #1;
        stb_out[k] = 1'b0;
    endtask
    // status is only read once the device runs again
    task automatic read(input logic [1:0] s, output logic [3:0] d);
        pulse(3, s);
        d = data_in;
    endtask
endmodule

/* File: bench/fdm_core_tb.sv */
`timescale 1ns/10ps
module fdm_core_tb import fdm_pkg::*; ;
    localparam logic [23:0] TXL = 24'h000014;
    localparam logic [23:0] NRL = 24'h00001e;
    logic       clk, rst_n, batt, ovr, und, warn, rot, vddu, rxs, txp, lot, sot, wdf;
    logic       hv, smask, lmask, swmask, irqn, txen, regen, hrstn, wdfb, x, stp, wk;
    logic [1:0] sopen, slim, sctl, swon, sel;
    logic [3:0] stb, data, code, d;
    logic [2:0] mode;
    logic [3:0] exp_q[$];
    int         errors, n_tests, i, e;

    fdm_core #(.TXSTUCK_LIMIT(TXL), .NREQ_LIMIT(NRL)) i_dut (
        .sys_clk_in(clk), .rst_n_in(rst_n), .clk_en_in(1'b1),
        .batt_low_in(batt), .supply_over_in(ovr), .supply_under_in(und),
        .reg_warn_in(warn), .reg_overtemp_in(rot), .vdd_under_in(vddu),
        .rx_short_in(rxs), .tx_pin_in(txp), .line_overtemp_in(lot),
        .switch_overtemp_in(sot), .switch_open_in(sopen), .switch_limit_in(slim),
        .wd_pin_float_in(wdf), .wake_in(wk), .go_normal_in(stb[0]),
        .go_stop_in(stp), .go_sleep_in(1'b0), .status_sel_in(sel),
        .status_rd_in(stb[3]), .irq_src_rd_in(stb[1]), .switch_ctrl_wr_in(stb[2]),
        .switch_ctrl_in(sctl), .high_voltage_shutdown_enable_in(hv),
        .supply_irq_mask_in(smask), .line_irq_mask_in(lmask),
        .switch_irq_mask_in(swmask), .status_data_out(data), .irq_source_out(code),
        .irq_n_out(irqn), .switch_on_out(swon), .tx_enable_out(txen),
        .reg_enable_out(regen), .host_reset_n_out(hrstn), .wd_fallback_out(wdfb),
        .mode_out(mode)
    );
    fdm_host i_host (.clk_in(clk), .data_in(data), .stb_out(stb), .sel_out(sel));

    // 10 MHz clock
    always #50 clk = ~clk;

    task automatic print_verdict();
        if (errors == 0 && n_tests > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    // compare a word result
    task automatic chk_word(input logic [3:0] got, input logic [3:0] exp);
        n_tests++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // compare a single pin result
    task automatic chk_bit(input logic got, input logic exp);
        chk_word({3'h0, got}, {3'h0, exp});
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // bounded wait for a mode, giving up ends the run
    task automatic wait_mode(input logic [2:0] m);
        for (int k = 0; k < 80 && mode !== m; k++) cyc(1);
        chk_word({1'b0, mode}, {1'b0, m});
        if (mode !== m) print_verdict();
    endtask
    task automatic rd(input logic [1:0] s, input logic [3:0] exp);
        i_host.read(s, d);
        chk_word(d, exp);
    endtask
    task automatic irq_chk(input logic n, input logic [3:0] c);
        chk_bit(irqn, n);
        chk_word(code, c);
    endtask

    initial begin
        errors = 0;
        n_tests = 0;
        clk = 1'b0;
        rst_n = 1'b0;
        {batt, ovr, und, warn, rot, vddu, rxs, lot, sot, wdf, hv, stp, wk} = 13'h0000;
        {sopen, slim} = 4'h0;
        {txp, smask, lmask, swmask} = 4'hf;
        sctl = 2'h3;
        void'($urandom(25992));
        cyc(16);
        chk_word({1'b0, mode}, 4'h0);
        chk_bit(hrstn, 1'b0);
        chk_bit(regen, 1'b1);
        rst_n = 1'b1;
        wait_mode(FDM_NORM_REQ);
        cyc(int'(NRL) - 5);
        chk_word({1'b0, mode}, {1'b0, FDM_NORM_REQ});
        wait_mode(FDM_RESET);
        wait_mode(FDM_NORM_REQ);
        i_host.pulse(0, 2'h0);
        wait_mode(FDM_NORMAL);
        cyc(4);
        chk_bit(hrstn, 1'b1);
        // random supply, switch and watchdog levels against the flag model
        for (i = 0; i < 6; i++) begin
            e = $urandom;
            {ovr, und, warn, batt} = 4'(e);
            {sopen, slim, sctl} = 6'(e >> 4);
            {wdf, smask} = 2'(e >> 10);
            x = smask & (ovr | und | warn);
            // model queue: supply, switch, watchdog words in read order
            exp_q = '{{ovr, und, warn, batt}, {sopen[1], slim[1], sopen[0], slim[0]},
                      {1'b0, wdf, 2'h0}};
            cyc(6);
            rd(SEL_SUPPLY, exp_q.pop_front());
            irq_chk(~x, x ? IRQ_CODE_SUPPLY : IRQ_CODE_NONE);
            rd(SEL_SWITCH, exp_q.pop_front());
            chk_word({2'h0, swon}, {2'h0, sctl});
            rd(SEL_WATCHDOG, exp_q.pop_front());
            chk_bit(wdfb, wdf);
            i_host.pulse(1, 2'h0);
            cyc(2);
            chk_bit(irqn, 1'b1);
            {ovr, und, warn, batt, sopen, slim, wdf} = 9'h000;
            cyc(6);
        end
        // receive pin short, then stuck dominant transmit input
        rxs = 1'b1;
        cyc(6);
        chk_bit(txen, 1'b0);
        irq_chk(1'b0, IRQ_CODE_LINE);
        rd(SEL_LINE, 4'h8);
        i_host.pulse(1, 2'h0);
        rxs = 1'b0;
        cyc(6);
        rd(SEL_LINE, 4'h8);
        rd(SEL_LINE, 4'h0);
        chk_bit(txen, 1'b1);
        txp = 1'b0;
        cyc(int'(TXL) - 2);
        chk_bit(txen, 1'b1);
        cyc(12);
        chk_bit(txen, 1'b0);
        irq_chk(1'b0, IRQ_CODE_LINE);
        rd(SEL_LINE, 4'h4);
        i_host.pulse(1, 2'h0);
        txp = 1'b1;
        cyc(4);
        chk_bit(txen, 1'b1);
        rd(SEL_LINE, 4'h4);
        rd(SEL_LINE, 4'h0);
        // masked line driver overheat
        lmask = 1'b0;
        lot = 1'b1;
        cyc(6);
        chk_bit(txen, 1'b0);
        rd(SEL_LINE, 4'h2);
        irq_chk(1'b1, IRQ_CODE_NONE);
        lot = 1'b0;
        lmask = 1'b1;
        cyc(6);
        rd(SEL_LINE, 4'h0);
        chk_bit(txen, 1'b1);
        // switch overheat, unmasked then masked
        sctl = 2'h3;
        for (i = 0; i < 2; i++) begin
            swmask = ~i[0];
            sot = 1'b1;
            cyc(6);
            chk_word({2'h0, swon}, 4'h0);
            rd(SEL_SWITCH, SW_ALL_FLAGS);
            irq_chk(~swmask, swmask ? IRQ_CODE_SWITCH : IRQ_CODE_NONE);
            i_host.pulse(1, 2'h0);
            sot = 1'b0;
            cyc(6);
            chk_word({2'h0, swon}, 4'h0);
            i_host.pulse(2, 2'h0);
            cyc(2);
            chk_word({2'h0, swon}, {2'h0, sctl});
        end
        // overvoltage switch shutdown when enabled
        hv = 1'b1;
        smask = 1'b0;
        ovr = 1'b1;
        cyc(6);
        chk_word({2'h0, swon}, 4'h0);
        ovr = 1'b0;
        cyc(6);
        i_host.pulse(2, 2'h0);
        cyc(2);
        chk_word({2'h0, swon}, {2'h0, sctl});
        // stop mode: warning flag held off, supply interrupt still raised
        smask = 1'b1;
        stp = 1'b1;
        cyc(1);
        stp = 1'b0;
        wait_mode(FDM_STOP);
        warn = 1'b1;
        cyc(6);
        irq_chk(1'b1, IRQ_CODE_NONE);
        und = 1'b1;
        cyc(6);
        irq_chk(1'b0, IRQ_CODE_SUPPLY);
        {warn, und, wk} = 3'h1;
        wait_mode(FDM_NORMAL);
        wk = 1'b0;
        rd(SEL_SUPPLY, 4'h0);
        i_host.pulse(1, 2'h0);
        // regulator overheat: reset then sleep, no interrupts there
        smask = 1'b1;
        rot = 1'b1;
        wait_mode(FDM_RESET);
        rot = 1'b0;
        wait_mode(FDM_SLEEP);
        chk_bit(regen, 1'b0);
        und = 1'b1;
        cyc(6);
        irq_chk(1'b1, IRQ_CODE_NONE);
        und = 1'b0;
        rst_n = 1'b0;
        cyc(2);
        rst_n = 1'b1;
        wait_mode(FDM_NORM_REQ);
        vddu = 1'b1;
        wait_mode(FDM_RESET);
        wait_mode(FDM_SLEEP);
        print_verdict();
    end
endmodule
